// File: rtl/brsel_pkg.sv
// Contract
// - Select field 10 makes every off-time recirculate through the low-side switches with slow decay.
// - Select field 01 makes every off-time recirculate through the high-side switches with slow decay.
// - In automatic mode (00) with falling bemf, use low-side from period start and high-side after the crossing.
// - In automatic mode with rising bemf, use high-side from period start and low-side after the crossing.
// - Select field 11 turns every bridge switch off during the off-time so current decays through the diodes.
// - The crossing comparator output passes a digital filter before the crossing is reported.
// - Degauss compensation is applied when its enable bit is 1 and not applied when it is 0.
// - After reset the select field holds 00, automatic mixed slow decay.
package brsel_pkg;

    // ------------------------------------------------------------
    // Path select codes
    // ------------------------------------------------------------
    localparam logic [1:0] BRSEL_AUTO      = 2'h0;
    localparam logic [1:0] BRSEL_HIGH      = 2'h1;
    localparam logic [1:0] BRSEL_LOW       = 2'h2;
    localparam logic [1:0] BRSEL_NONSYNC   = 2'h3;
    localparam logic [1:0] BRSEL_RST_PATH  = 2'h0;

    // ------------------------------------------------------------
    // Filter and degauss counts
    // ------------------------------------------------------------
    localparam int         BRSEL_FILT_LEN  = 4;
    localparam int         BRSEL_DG_MAX    = 255;
    localparam int         BRSEL_DG_W      = 8;

    // ------------------------------------------------------------
    // Recirculation path in use
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BRSEL_REC_LOW,
        BRSEL_REC_HIGH,
        BRSEL_REC_NONE
    } brsel_rec_e;

endpackage : brsel_pkg

// File: rtl/brsel_zc_filter.sv
`timescale 1ns/1ps
`default_nettype none
module brsel_zc_filter #(
    parameter int FILT_LEN = brsel_pkg::BRSEL_FILT_LEN
) (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic arst_n_in,
    // Sample stream
    input  wire logic sample_valid_in,
    input  wire logic sample_in,
    // Filtered level
    output logic      level_out
);

    // ------------------------------------------------------------
    // Majority-free run filter
    // ------------------------------------------------------------
    logic [FILT_LEN-2:0] hist;
    logic                level;
    wire                 all_one  = &{hist, sample_in};
    wire                 all_zero = ~|{hist, sample_in};
    wire                 next_level = all_one ? 1'b1 : (all_zero ? 1'b0 : level);

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hist  <= '0;
            level <= 1'b0;
        end else if (sample_valid_in) begin
            hist  <= (FILT_LEN-1)'({hist, sample_in});
            level <= next_level;
        end
    end

    assign level_out = level;

endmodule : brsel_zc_filter
`default_nettype wire

// File: rtl/brsel_top.sv
`timescale 1ns/1ps
`default_nettype none
module brsel_top #(
    parameter int FILT_LEN = brsel_pkg::BRSEL_FILT_LEN,
    parameter int DG_W     = brsel_pkg::BRSEL_DG_W
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       arst_n_in,
    // Configuration
    input  wire logic       cfg_load_in,
    input  wire logic [1:0] recirc_path_select_in,
    input  wire logic       degauss_comp_enable_in,
    // Commutation controller
    input  wire logic       commutate_in,
    input  wire logic       bemf_rising_in,
    input  wire logic       pwm_on_in,
    input  wire logic       drive_hs_in,
    input  wire logic       drive_ls_in,
    // Analog comparators (asynchronous)
    input  wire logic       zc_comp_in,
    input  wire logic       clamp_high_in,
    input  wire logic       clamp_low_in,
    // Bridge gate commands for the PWM phase
    output logic            gate_hs_out,
    output logic            gate_ls_out,
    // Status
    output logic [1:0]      recirc_path_select_out,
    output logic [1:0]      rec_path_out,
    output logic            zc_level_out,
    output logic            zc_detect_out,
    output logic            degauss_active_out
);

    // ------------------------------------------------------------
    // Configuration
    // ------------------------------------------------------------
    logic [1:0] path_sel;
    logic       dg_en;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            path_sel <= brsel_pkg::BRSEL_RST_PATH;
            dg_en    <= 1'b0;
        end else if (cfg_load_in) begin
            path_sel <= recirc_path_select_in;
            dg_en    <= degauss_comp_enable_in;
        end
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [2:0] sync1;
    logic [2:0] sync2;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {clamp_low_in, clamp_high_in, zc_comp_in};
            sync2 <= sync1;
        end
    end

    wire zc_s      = sync2[0];
    wire clamped_s = sync2[1] | sync2[2];

    // ------------------------------------------------------------
    // Degauss window after commutation
    // ------------------------------------------------------------
    logic degauss;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            degauss <= 1'b0;
        end else if (commutate_in) begin
            degauss <= dg_en;
        end else if (!clamped_s || !dg_en) begin
            degauss <= 1'b0;
        end
    end

    wire sample_ok = !(degauss && clamped_s);

    // ------------------------------------------------------------
    // Zero-crossing filter and detection
    // ------------------------------------------------------------
    logic zc_level;
    logic zc_prev;
    logic zc_seen;
    logic zc_pulse;
    logic rising_exp;

    brsel_zc_filter #(
        .FILT_LEN        (FILT_LEN)
    ) u_filter (
        .clk_in          (clk_in),
        .arst_n_in       (arst_n_in),
        .sample_valid_in (sample_ok),
        .sample_in       (zc_s),
        .level_out       (zc_level)
    );

    wire zc_edge = (zc_level != zc_prev) && (zc_level == rising_exp);

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            zc_prev    <= 1'b0;
            zc_seen    <= 1'b0;
            zc_pulse   <= 1'b0;
            rising_exp <= 1'b0;
        end else begin
            zc_prev  <= zc_level;
            zc_pulse <= zc_edge && !zc_seen && !commutate_in;
            if (commutate_in) begin
                zc_seen    <= 1'b0;
                rising_exp <= bemf_rising_in;
            end else if (zc_edge) begin
                zc_seen <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Recirculation path choice
    // ------------------------------------------------------------
    logic [1:0] next_rec;

    always_comb begin
        next_rec = brsel_pkg::BRSEL_REC_LOW;
        unique case (path_sel)
            brsel_pkg::BRSEL_LOW:     next_rec = brsel_pkg::BRSEL_REC_LOW;
            brsel_pkg::BRSEL_HIGH:    next_rec = brsel_pkg::BRSEL_REC_HIGH;
            brsel_pkg::BRSEL_NONSYNC: next_rec = brsel_pkg::BRSEL_REC_NONE;
            brsel_pkg::BRSEL_AUTO: begin
                if (rising_exp ^ zc_seen) begin
                    next_rec = brsel_pkg::BRSEL_REC_HIGH;
                end else begin
                    next_rec = brsel_pkg::BRSEL_REC_LOW;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Gate outputs
    // ------------------------------------------------------------
    logic [1:0] rec_path;
    logic       gate_hs;
    logic       gate_ls;
    wire        off_hs = (next_rec == brsel_pkg::BRSEL_REC_HIGH);
    wire        off_ls = (next_rec == brsel_pkg::BRSEL_REC_LOW);
    wire        next_hs = pwm_on_in ? drive_hs_in : off_hs;
    wire        next_ls = pwm_on_in ? drive_ls_in : off_ls;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rec_path <= brsel_pkg::BRSEL_REC_LOW;
            gate_hs  <= 1'b0;
            gate_ls  <= 1'b0;
        end else begin
            rec_path <= next_rec;
            gate_hs  <= next_hs;
            gate_ls  <= next_ls;
        end
    end

    assign gate_hs_out            = gate_hs;
    assign gate_ls_out            = gate_ls;
    assign recirc_path_select_out = path_sel;
    assign rec_path_out           = rec_path;
    assign zc_level_out           = zc_level;
    assign zc_detect_out          = zc_pulse;
    assign degauss_active_out     = degauss;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_offtime;
        !pwm_on_in;
    endsequence

    chk_low_path_fixed: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        ((path_sel == brsel_pkg::BRSEL_LOW) and s_offtime) |=> gate_ls && !gate_hs)
        else $error("low path not used in off-time");

    chk_high_path_fixed: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        ((path_sel == brsel_pkg::BRSEL_HIGH) and s_offtime) |=> gate_hs && !gate_ls)
        else $error("high path not used in off-time");

    chk_auto_falling_path: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (((path_sel == brsel_pkg::BRSEL_AUTO) && !rising_exp) and s_offtime)
        |=> (gate_hs == $past(zc_seen)) && (gate_ls == !$past(zc_seen)))
        else $error("auto path wrong for falling bemf");

    chk_auto_rising_path: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (((path_sel == brsel_pkg::BRSEL_AUTO) && rising_exp) and s_offtime)
        |=> (gate_ls == $past(zc_seen)) && (gate_hs == !$past(zc_seen)))
        else $error("auto path wrong for rising bemf");

    chk_nonsync_all_off: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        ((path_sel == brsel_pkg::BRSEL_NONSYNC) and s_offtime) |=> !gate_hs && !gate_ls)
        else $error("switch on in non-synchronous off-time");

    chk_filter_detect_ok: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        zc_pulse |-> $past(zc_level != zc_prev) && !$past(commutate_in))
        else $error("crossing reported without filtered edge");

    chk_degauss_gated_en: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        commutate_in |=> (degauss == $past(dg_en)))
        else $error("degauss window does not follow enable");

    chk_reset_path_auto: assert property (@(posedge clk_in)
        $rose(arst_n_in) |-> (path_sel == brsel_pkg::BRSEL_AUTO))
        else $error("path select not automatic after reset");

    chk_clamp_hold_filter: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        degauss && clamped_s && !commutate_in |=> $stable(zc_level))
        else $error("filter moved during clamp");

endmodule : brsel_top
`default_nettype wire

// File: verif/brsel_bridge_model.sv
`timescale 1ns/1ps
`default_nettype none
module brsel_bridge_model (
    // Gate commands
    input  wire logic       gate_hs_in,
    input  wire logic       gate_ls_in,
    // Motor state
    input  wire logic       bemf_pos_in,
    input  wire logic [1:0] clamp_in,
    // Sensed phase
    output logic            zc_comp_out,
    output logic            clamp_high_out,
    output logic            clamp_low_out,
    output logic            shorted_out
);
    // ------------------------------------------------------------
    // Comparator and rail clamps, unrelated to the clock
    // ------------------------------------------------------------
    assign #3 zc_comp_out    = bemf_pos_in;
    assign #5 clamp_high_out = clamp_in[1];
    assign #5 clamp_low_out  = clamp_in[0];
    // ------------------------------------------------------------
    // Shoot-through watch
    // ------------------------------------------------------------
    initial shorted_out = 1'b0;
    always @(gate_hs_in or gate_ls_in) begin
        #1;
        if (gate_hs_in && gate_ls_in) begin
            shorted_out = 1'b1;
        end
    end
endmodule : brsel_bridge_model
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       clk_in    = 1'b0;
    logic       arst_n_in = 1'b0;
    logic       cfg_load  = 1'b0;
    logic [1:0] sel       = 2'h0;
    logic       dg_en     = 1'b0;
    logic       commut    = 1'b0;
    logic       rising    = 1'b0;
    logic       pwm_on    = 1'b0;
    logic       dhs       = 1'b0;
    logic       dls       = 1'b0;
    logic       bemf_pos  = 1'b0;
    logic [1:0] clamp     = 2'h0;
    wire logic  zc, ch, cl, ghs, gls, zcl, det, dga, shorted;
    wire logic [1:0] sel_o, rec;
    int errors = 0;
    int checks = 0;
    initial forever #10 clk_in = ~clk_in;
    brsel_top u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .cfg_load_in(cfg_load),
        .recirc_path_select_in(sel), .degauss_comp_enable_in(dg_en), .commutate_in(commut),
        .bemf_rising_in(rising), .pwm_on_in(pwm_on), .drive_hs_in(dhs), .drive_ls_in(dls),
        .zc_comp_in(zc), .clamp_high_in(ch), .clamp_low_in(cl), .gate_hs_out(ghs),
        .gate_ls_out(gls), .recirc_path_select_out(sel_o), .rec_path_out(rec),
        .zc_level_out(zcl), .zc_detect_out(det), .degauss_active_out(dga));
    brsel_bridge_model u_bridge (.gate_hs_in(ghs), .gate_ls_in(gls), .bemf_pos_in(bemf_pos),
        .clamp_in(clamp), .zc_comp_out(zc), .clamp_high_out(ch), .clamp_low_out(cl),
        .shorted_out(shorted));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [1:0] seen, input logic [1:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask : cyc
    task automatic load(input logic [1:0] s, input logic e);
        @(negedge clk_in);
        sel = s;
        dg_en = e;
        cfg_load = 1'b1;
        @(negedge clk_in);
        cfg_load = 1'b0;
    endtask : load
    task automatic commute(input logic r, input logic start);
        bemf_pos = start;
        cyc(12);
        rising = r;
        commut = 1'b1;
        @(negedge clk_in);
        commut = 1'b0;
        cyc(2);
    endtask : commute
    task automatic wait_det(input logic must, output logic found);
        found = 1'b0;
        for (int i = 0; i < 20 && !found; i++) begin
            @(negedge clk_in);
            found = (det === 1'b1);
        end
        if (must && !found) begin
            errors++;
            $display("ERROR zc_detect expected 1 seen 0");
            give_verdict();
        end
    endtask : wait_det
    task automatic give_verdict();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_fixed();
        logic [1:0] codes [3] = '{brsel_pkg::BRSEL_LOW, brsel_pkg::BRSEL_HIGH, brsel_pkg::BRSEL_NONSYNC};
        logic [1:0] recs [3] = '{2'h0, 2'h1, 2'h2};
        logic [1:0] gates [3] = '{2'h1, 2'h2, 2'h0};
        for (int i = 0; i < 3; i++) begin
            load(codes[i], 1'b0);
            cyc(2);
            chk("sel_out", sel_o, codes[i]);
            chk("rec_path", rec, recs[i]);
            chk("gates", {ghs, gls}, gates[i]);
        end
        pwm_on = 1'b1;
        dhs = 1'b1;
        cyc(2);
        chk("gates_on", {ghs, gls}, 2'h2);
        dhs = 1'b0;
        cyc(1);
        dls = 1'b1;
        cyc(2);
        chk("gates_on_ls", {ghs, gls}, 2'h1);
        pwm_on = 1'b0;
        dls = 1'b0;
    endtask : t_fixed
    task automatic t_auto(input logic r);
        logic found;
        load(brsel_pkg::BRSEL_AUTO, 1'b0);
        commute(r, !r);
        chk("rec_start", rec, r ? 2'h1 : 2'h0);
        bemf_pos = r;
        cyc(2);
        bemf_pos = !r;
        wait_det(1'b0, found);
        chk("zc_glitch", {1'b0, found}, 2'h0);
        bemf_pos = r;
        wait_det(1'b1, found);
        cyc(2);
        chk("zc_level", {1'b0, zcl}, {1'b0, r});
        chk("rec_after", rec, r ? 2'h0 : 2'h1);
        chk("gates_after", {ghs, gls}, r ? 2'h1 : 2'h2);
    endtask : t_auto
    task automatic t_degauss();
        logic found;
        load(brsel_pkg::BRSEL_AUTO, 1'b1);
        clamp = 2'h2;
        commute(1'b1, 1'b0);
        chk("degauss_on", {1'b0, dga}, 2'h1);
        bemf_pos = 1'b1;
        wait_det(1'b0, found);
        chk("zc_in_clamp", {1'b0, found}, 2'h0);
        clamp = 2'h0;
        wait_det(1'b1, found);
        chk("degauss_end", {1'b0, dga}, 2'h0);
        load(brsel_pkg::BRSEL_AUTO, 1'b0);
        clamp = 2'h1;
        commute(1'b1, 1'b0);
        chk("degauss_off", {1'b0, dga}, 2'h0);
        bemf_pos = 1'b1;
        wait_det(1'b1, found);
        clamp = 2'h0;
    endtask : t_degauss
    initial begin
        cyc(4);
        arst_n_in = 1'b1;
        chk("sel_reset", sel_o, brsel_pkg::BRSEL_RST_PATH);
        chk("gates_reset", {ghs, gls}, 2'h0);
        t_fixed();
        t_auto(1'b0);
        t_auto(1'b1);
        t_degauss();
        chk("shorted", {1'b0, shorted}, 2'h0);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
